// ===== pcp_pkg.sv
// Constants, register offsets and carrier types for the port C pin logic.
// Assumes a single 10 MHz core clock and a word-per-register plain port.
package pcp_pkg;

    // Port geometry
    localparam int unsigned PCP_NPIN   = 8;
    localparam int unsigned PCP_ADDR_W = 2;

    // Register offsets on the plain register port
    localparam logic [1:0] PCP_OFF_VALUE = 2'h0;
    localparam logic [1:0] PCP_OFF_LATCH = 2'h1;
    localparam logic [1:0] PCP_OFF_DIR   = 2'h2;

    // Reset values: every pin an input, latch cleared
    localparam logic [7:0] PCP_DIR_RST   = 8'hFF;
    localparam logic [7:0] PCP_LATCH_RST = 8'h00;
    localparam logic [7:0] PCP_ZERO      = 8'h00;

    // Pin positions of the shared functions
    localparam int unsigned PCP_PIN_OSC_OUT = 0;
    localparam int unsigned PCP_PIN_OSC_IN  = 1;
    localparam int unsigned PCP_PIN_CMP1    = 2;
    localparam int unsigned PCP_PIN_SCK     = 3;
    localparam int unsigned PCP_PIN_SDA     = 4;
    localparam int unsigned PCP_PIN_SDO     = 5;
    localparam int unsigned PCP_PIN_TX      = 6;
    localparam int unsigned PCP_PIN_RX      = 7;

    // Requests from the on-chip peripherals toward the pins
    typedef struct packed {
        logic osc_en;      // Timer oscillator owns pins 0 and 1
        logic cmp1_oe;     // First compare channel drives
        logic cmp1_out;
        logic cmp2_oe;     // Second compare channel drives
        logic cmp2_out;
        logic cmp2_route;  // Routing bit: 1 puts channel on pin 1
        logic ssp_spi;     // Serial module in SPI mode
        logic ssp_i2c;     // Serial module in two-wire mode
        logic sck_out;     // SPI clock output
        logic sdo;         // SPI data output
        logic scl_drv;     // Two-wire clock pulled low
        logic sda_drv;     // Two-wire data pulled low
        logic ua_async;    // USART asynchronous mode
        logic ua_sync;     // USART synchronous mode
        logic ua_master;   // Synchronous clock master
        logic tx_out;      // Asynchronous transmit data
        logic uclk_out;    // Synchronous clock output
        logic udat_tx;     // Synchronous data transmitting
        logic udat_out;    // Synchronous data output
    } pcp_periph_req_t;

    // Pin levels handed back to the peripherals
    typedef struct packed {
        logic tmr_in;
        logic cmp1_cap;
        logic cmp2_cap;
        logic sck_in;
        logic scl_in;
        logic sdi;
        logic sda_in;
        logic rx;
        logic uclk_in;
        logic udat_in;
    } pcp_periph_in_t;

endpackage : pcp_pkg

// ===== pcp_pin_mux.sv
// Per-pin driver and input selection for the port, purely combinational.
// Assumes the caller registers the results before they reach any pin.
module pcp_pin_mux
    import pcp_pkg::*;
#(
    parameter int unsigned N = PCP_NPIN
)
(
    input  wire logic [N-1:0] latch,
    input  wire logic [N-1:0] dir,
    input  wire logic [N-1:0] take,
    input  wire logic [N-1:0] pval,
    input  wire logic [N-1:0] frc_oe,
    input  wire logic [N-1:0] frc_hiz,
    input  wire logic [N-1:0] dig_off,
    input  wire logic [N-1:0] pin_in,
    output wire logic [N-1:0] oe,
    output wire logic [N-1:0] out,
    output wire logic [N-1:0] rd
);

    genvar i;

    // One slice per pin; peripheral forcing beats the direction bit
    generate
        for (i = 0; i < N; i++)
        begin : g_pin
            assign oe[i]  = frc_hiz[i] ? 1'b0 : (frc_oe[i] | ~dir[i]);
            assign out[i] = take[i] ? pval[i] : latch[i];
            // Analog-owned pins read as zero, digital input disabled
            assign rd[i]  = dig_off[i] ? 1'b0 : pin_in[i];
        end
    endgenerate

endmodule : pcp_pin_mux

// ===== pcp_port.sv
// Port C pin logic: latch, direction and pin value registers with
// peripheral overrides for the serial modules and compare channels.
// Assumes pin inputs synchronous to clk and a one-cycle register port.
// Pads resolve the wire from pin_out_q and pin_oe_q.
//
// Chosen here: the strobed register port and the register offsets.

// Contract
// - Latch register reads and writes reach stored latch, not pin levels.
// - Two-wire mode samples clock and data pins as inputs.
// - Two-wire data drive replaces latch value on pin 4.
// - SPI mode feeds pin 4 to the SPI receiver as input.
// - SPI data output on pin 5 beats latch data when direction is 0.
// - Asynchronous transmit takes pin 6; software still sets its direction.
// - Synchronous clock on pin 6: driven as master, sampled as slave.
// - Asynchronous mode feeds pin 7 to the receiver as input.
// - Synchronous data on pin 7: driven while sending, sampled receiving.
// - Don't-care functions ignore the direction bit or override it.
// - Second compare channel on pin 1 when routed, else alternate pin.
// - Direction reads return stored bits despite peripheral overrides.
// - After reset every pin is a digital input.
// - Two-wire clock drive on pin 3 beats latch data.
module pcp_port
    import pcp_pkg::*;
#(
    parameter int unsigned NPIN = PCP_NPIN
)
(
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic [PCP_ADDR_W-1:0] bus_addr,
    input  wire logic [NPIN-1:0]       bus_wdata,
    input  wire logic                  bus_wr,
    input  wire logic                  bus_rd,
    output logic      [NPIN-1:0]       bus_rdata_q,
    input  wire logic [NPIN-1:0]       pin_in,
    output logic      [NPIN-1:0]       pin_out_q,
    output logic      [NPIN-1:0]       pin_oe_q,
    input  wire pcp_periph_req_t       per_req,
    output pcp_periph_in_t             per_in_q,
    input  wire logic                  alt_pin3_in,
    output logic                       alt_cmp2_oe_q,
    output logic                       alt_cmp2_out_q
);

    // Stored state
    logic [NPIN-1:0] latch_q;
    logic [NPIN-1:0] latch_d;
    logic [NPIN-1:0] dir_q;
    logic [NPIN-1:0] dir_d;
    logic [NPIN-1:0] rdata_d;
    pcp_periph_in_t  per_in_d;
    logic            first_q;

    // Override vectors toward the pin slices
    logic [NPIN-1:0] take_v;
    logic [NPIN-1:0] pval_v;
    logic [NPIN-1:0] frc_oe_v;
    logic [NPIN-1:0] frc_hiz_v;
    logic [NPIN-1:0] dig_off_v;
    logic [NPIN-1:0] mux_oe;
    logic [NPIN-1:0] mux_out;
    logic [NPIN-1:0] mux_rd;

    // Register port decode
    wire hit_val = bus_addr == PCP_OFF_VALUE;
    wire hit_lat = bus_addr == PCP_OFF_LATCH;
    wire hit_dir = bus_addr == PCP_OFF_DIR;
    // Writing the pin value register lands in the latch as well
    wire wr_lat  = bus_wr && (hit_val || hit_lat);
    wire wr_dir  = bus_wr && hit_dir;

    assign latch_d = wr_lat ? bus_wdata : latch_q;
    assign dir_d   = wr_dir ? bus_wdata : dir_q;

    // Read selection; unmapped offset answers zero
    wire [NPIN-1:0] rd_sel = hit_val ? mux_rd :
                             hit_lat ? latch_q :
                             hit_dir ? dir_q :
                             PCP_ZERO;
    // Data stand only in the cycle after the strobe
    assign rdata_d = bus_rd ? rd_sel : PCP_ZERO;

    // Peripheral mode terms
    wire i2c   = per_req.ssp_i2c;
    wire spi   = per_req.ssp_spi && !per_req.ssp_i2c;
    wire async = per_req.ua_async && !per_req.ua_sync;
    wire sync  = per_req.ua_sync;
    wire c2_on = per_req.cmp2_route && per_req.cmp2_oe;

    // Pin 0: oscillator owns it, direction bit is don't-care
    wire t0_hiz = per_req.osc_en;

    // Pin 1: oscillator input or routed compare channel
    wire t1_take = c2_on && !per_req.osc_en;
    wire t1_hiz  = per_req.osc_en;

    // Pin 2: first compare channel beats latch data
    wire t2_take = per_req.cmp1_oe;

    // Pin 3: two-wire clock is open-drain low drive, SPI clock replaces latch data under the direction bit
    wire t3_take = i2c || spi;
    wire t3_val  = i2c ? 1'b0 : per_req.sck_out;
    wire t3_oe   = i2c && per_req.scl_drv;
    wire t3_hiz  = i2c && !per_req.scl_drv;

    // Pin 4: two-wire data drive wins whatever the latch holds
    wire t4_take = i2c;
    wire t4_oe   = i2c && per_req.sda_drv;
    wire t4_hiz  = i2c && !per_req.sda_drv;

    // Pin 5: SPI data output under the direction bit
    wire t5_take = spi;

    // Pin 6: transmit data or synchronous clock
    wire t6_take = async || (sync && per_req.ua_master);
    wire t6_val  = sync ? per_req.uclk_out : per_req.tx_out;
    wire t6_oe   = sync && per_req.ua_master;
    wire t6_hiz  = sync && !per_req.ua_master;

    // Pin 7: receive input or synchronous data
    // Synchronous receiving leaves direction to software so a misconfigured pin shows
    wire t7_take = sync && per_req.udat_tx;
    wire t7_oe   = sync && per_req.udat_tx;
    wire t7_hiz  = async;

    // Gather per-pin terms into vectors, pin 7 first
    assign take_v    = {t7_take, t6_take, t5_take, t4_take,
                        t3_take, t2_take, t1_take, 1'b0};
    assign pval_v    = {per_req.udat_out, t6_val, per_req.sdo, 1'b0,
                        t3_val, per_req.cmp1_out, per_req.cmp2_out, 1'b0};
    assign frc_oe_v  = {t7_oe, t6_oe, 1'b0, t4_oe,
                        t3_oe, 1'b0, 1'b0, 1'b0};
    assign frc_hiz_v = {t7_hiz, t6_hiz, 1'b0, t4_hiz,
                        t3_hiz, 1'b0, t1_hiz, t0_hiz};
    assign dig_off_v = {6'h00, per_req.osc_en, per_req.osc_en};

    // Per-pin slices
    pcp_pin_mux #(
        .N       (NPIN)
    ) u_mux (
        .latch   (latch_q),
        .dir     (dir_q),
        .take    (take_v),
        .pval    (pval_v),
        .frc_oe  (frc_oe_v),
        .frc_hiz (frc_hiz_v),
        .dig_off (dig_off_v),
        .pin_in  (pin_in),
        .oe      (mux_oe),
        .out     (mux_out),
        .rd      (mux_rd)
    );

    // Pin levels toward the peripherals
    // Two-wire thresholds live in the pad; digitally the same sample
    always_comb
    begin
        per_in_d          = '0;
        per_in_d.tmr_in   = mux_rd[PCP_PIN_OSC_OUT];
        per_in_d.cmp2_cap = per_req.cmp2_route ? mux_rd[PCP_PIN_OSC_IN]
                                               : alt_pin3_in;
        per_in_d.cmp1_cap = mux_rd[PCP_PIN_CMP1];
        per_in_d.sck_in   = mux_rd[PCP_PIN_SCK];
        per_in_d.scl_in   = mux_rd[PCP_PIN_SCK];
        per_in_d.sdi      = mux_rd[PCP_PIN_SDA];
        per_in_d.sda_in   = mux_rd[PCP_PIN_SDA];
        per_in_d.rx       = mux_rd[PCP_PIN_RX];
        per_in_d.uclk_in  = mux_rd[PCP_PIN_TX];
        per_in_d.udat_in  = mux_rd[PCP_PIN_RX];
    end

    // Software registers; reset leaves every pin an input
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            latch_q <= PCP_LATCH_RST;
            dir_q   <= PCP_DIR_RST;
        end
        else
        begin
            latch_q <= latch_d;
            dir_q   <= dir_d;
        end
    end

    // Registered pins and answers, one cycle behind their causes
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_out_q      <= PCP_LATCH_RST;
            pin_oe_q       <= PCP_ZERO;
            bus_rdata_q    <= PCP_ZERO;
            per_in_q       <= '0;
            alt_cmp2_oe_q  <= 1'b0;
            alt_cmp2_out_q <= 1'b0;
        end
        else
        begin
            pin_out_q      <= mux_out;
            pin_oe_q       <= mux_oe;
            bus_rdata_q    <= rdata_d;
            per_in_q       <= per_in_d;
            alt_cmp2_oe_q  <= !per_req.cmp2_route && per_req.cmp2_oe;
            alt_cmp2_out_q <= per_req.cmp2_out;
        end
    end

    // Marks the first cycle after reset release, for checking only
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            first_q <= 1'b1;
        else
            first_q <= 1'b0;
    end

    // Checks
    sequence s_wr_latch;
        bus_wr && (bus_addr == PCP_OFF_LATCH);
    endsequence

    sequence s_rd_latch;
        bus_rd && (bus_addr == PCP_OFF_LATCH) && !bus_wr;
    endsequence

    property p_plain_drive;
        @(posedge clk) disable iff (!rst_b)
        (!per_req.cmp1_oe && !dir_q[PCP_PIN_CMP1])
        |=> pin_oe_q[PCP_PIN_CMP1]
            && (pin_out_q[PCP_PIN_CMP1] == $past(latch_q[PCP_PIN_CMP1]));
    endproperty
    a_plain_drive: assert property (p_plain_drive)
        else $error("pin 2 does not drive latch with direction 0");

    property p_value_read;
        @(posedge clk) disable iff (!rst_b)
        (bus_rd && hit_val && !per_req.osc_en) |=> bus_rdata_q == $past(pin_in);
    endproperty
    a_value_read: assert property (p_value_read)
        else $error("pin value read does not match pin levels");

    property p_latch_rw;
        @(posedge clk) disable iff (!rst_b)
        s_wr_latch ##1 s_rd_latch |=> bus_rdata_q == $past(bus_wdata, 2);
    endproperty
    a_latch_rw: assert property (p_latch_rw)
        else $error("latch read does not return written latch value");

    property p_i2c_input;
        @(posedge clk) disable iff (!rst_b)
        (i2c && !per_req.scl_drv && !per_req.sda_drv)
        |=> !pin_oe_q[PCP_PIN_SCK] && !pin_oe_q[PCP_PIN_SDA]
            && (per_in_q.sda_in == $past(pin_in[PCP_PIN_SDA]));
    endproperty
    a_i2c_input: assert property (p_i2c_input)
        else $error("two-wire pins not released as inputs");

    property p_sda_drive;
        @(posedge clk) disable iff (!rst_b)
        (i2c && per_req.sda_drv) |=> pin_oe_q[PCP_PIN_SDA] && !pin_out_q[PCP_PIN_SDA];
    endproperty
    a_sda_drive: assert property (p_sda_drive)
        else $error("two-wire data drive lost on pin 4");

    property p_sdi;
        @(posedge clk) disable iff (!rst_b)
        spi |=> per_in_q.sdi == $past(pin_in[PCP_PIN_SDA]);
    endproperty
    a_sdi: assert property (p_sdi)
        else $error("SPI receiver not fed from pin 4");

    property p_sdo;
        @(posedge clk) disable iff (!rst_b)
        (spi && !dir_q[PCP_PIN_SDO])
        |=> pin_oe_q[PCP_PIN_SDO] && (pin_out_q[PCP_PIN_SDO] == $past(per_req.sdo));
    endproperty
    a_sdo: assert property (p_sdo)
        else $error("SPI data output does not win on pin 5");

    property p_tx;
        @(posedge clk) disable iff (!rst_b)
        async |=> pin_out_q[PCP_PIN_TX] == $past(per_req.tx_out);
    endproperty
    a_tx: assert property (p_tx)
        else $error("transmit data not on pin 6");

    property p_sync_clk;
        @(posedge clk) disable iff (!rst_b)
        (sync && per_req.ua_master)
        |=> pin_oe_q[PCP_PIN_TX] && (pin_out_q[PCP_PIN_TX] == $past(per_req.uclk_out));
    endproperty
    a_sync_clk: assert property (p_sync_clk)
        else $error("synchronous master clock not driven on pin 6");

    property p_rx;
        @(posedge clk) disable iff (!rst_b)
        async |=> !pin_oe_q[PCP_PIN_RX] && (per_in_q.rx == $past(pin_in[PCP_PIN_RX]));
    endproperty
    a_rx: assert property (p_rx)
        else $error("pin 7 not a receive input");

    property p_udat_tx;
        @(posedge clk) disable iff (!rst_b)
        (sync && per_req.udat_tx)
        |=> pin_oe_q[PCP_PIN_RX] && (pin_out_q[PCP_PIN_RX] == $past(per_req.udat_out));
    endproperty
    a_udat_tx: assert property (p_udat_tx)
        else $error("synchronous data not driven on pin 7");

    property p_osc_owns;
        @(posedge clk) disable iff (!rst_b)
        per_req.osc_en |=> !pin_oe_q[PCP_PIN_OSC_OUT] && !pin_oe_q[PCP_PIN_OSC_IN];
    endproperty
    a_osc_owns: assert property (p_osc_owns)
        else $error("oscillator pins still driven");

    property p_cmp2_route;
        @(posedge clk) disable iff (!rst_b)
        (!per_req.cmp2_route && per_req.cmp2_oe)
        |=> alt_cmp2_oe_q && (alt_cmp2_out_q == $past(per_req.cmp2_out));
    endproperty
    a_cmp2_route: assert property (p_cmp2_route)
        else $error("second compare channel not sent to alternate pin");

    property p_dir_read;
        @(posedge clk) disable iff (!rst_b)
        (bus_rd && hit_dir) |=> bus_rdata_q == $past(dir_q);
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("direction read not the stored bits");

    property p_reset_input;
        @(posedge clk) disable iff (!rst_b)
        first_q |-> (dir_q == PCP_DIR_RST) && (pin_oe_q == PCP_ZERO);
    endproperty
    a_reset_input: assert property (p_reset_input)
        else $error("pins not inputs after reset");

    property p_scl_drive;
        @(posedge clk) disable iff (!rst_b)
        (i2c && per_req.scl_drv) |=> pin_oe_q[PCP_PIN_SCK] && !pin_out_q[PCP_PIN_SCK];
    endproperty
    a_scl_drive: assert property (p_scl_drive)
        else $error("two-wire clock drive lost on pin 3");

endmodule : pcp_port

// ===== pcp_pad_model.sv
// Pad and board model for the port pins: resolves each wire level.
// Assumes an external pull-up on every pin and a board driver per pin.
module pcp_pad_model
(
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] ext_oe,
    input  wire logic [7:0] ext_val,
    output wire logic [7:0] level
);
    timeunit 1ns;
    timeprecision 1ns;

    // Port driver first, then board driver, else the pull-up holds the line high.
    // An undriven pin never keeps its last value, so stale data cannot pass.
    assign level = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe);
endmodule : pcp_pad_model

// ===== tb_pcp_port.sv
// Self-checking bench for the port pin logic: register port and overrides.
// Assumes the pad model resolves pin levels and feeds them back as pin_in.
module tb_pcp_port;
    import pcp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic            clk;
    logic            rst_b;
    logic [1:0]      bus_addr;
    logic [7:0]      bus_wdata;
    logic            bus_wr;
    logic            bus_rd;
    logic [7:0]      bus_rdata_q;
    logic [7:0]      pin_in;
    logic [7:0]      pin_out_q;
    logic [7:0]      pin_oe_q;
    pcp_periph_req_t per_req;
    pcp_periph_in_t  per_in_q;
    logic            alt_pin3_in;
    logic            alt_cmp2_oe_q;
    logic            alt_cmp2_out_q;
    logic [7:0]      ext_oe;
    logic [7:0]      ext_val;
    pcp_periph_req_t r;
    int              fail_count;
    int              cmp_count;

    pcp_port pcp_port_inst (
        .clk            (clk),
        .rst_b          (rst_b),
        .bus_addr       (bus_addr),
        .bus_wdata      (bus_wdata),
        .bus_wr         (bus_wr),
        .bus_rd         (bus_rd),
        .bus_rdata_q    (bus_rdata_q),
        .pin_in         (pin_in),
        .pin_out_q      (pin_out_q),
        .pin_oe_q       (pin_oe_q),
        .per_req        (per_req),
        .per_in_q       (per_in_q),
        .alt_pin3_in    (alt_pin3_in),
        .alt_cmp2_oe_q  (alt_cmp2_oe_q),
        .alt_cmp2_out_q (alt_cmp2_out_q)
    );

    pcp_pad_model pcp_pad_model_inst (
        .pin_out (pin_out_q),
        .pin_oe  (pin_oe_q),
        .ext_oe  (ext_oe),
        .ext_val (ext_val),
        .level   (pin_in)
    );

    // 10 MHz core clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One-cycle write strobe, changed right after an edge
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clk);
        bus_rd   <= 1'b0;
        #1;
        chk("rdata", bus_rdata_q, exp);
    endtask : rd

    // Pins lag requests by one edge and sampled inputs by two, so three edges settle everything
    task automatic setp(input pcp_periph_req_t q, input logic [7:0] eo, input logic [7:0] ev,
                        input logic a3);
        @(posedge clk);
        per_req     <= q;
        ext_oe      <= eo;
        ext_val     <= ev;
        alt_pin3_in <= a3;
        repeat (3) @(posedge clk);
        #1;
    endtask : setp

    task automatic tend(input string name);
        $display("test %s done", name);
    endtask : tend

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        finish_test();
    end

    initial
    begin
        fail_count = 0;
        cmp_count = 0;
        rst_b = 1'b0;
        bus_addr = 2'h0;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        per_req = '0;
        ext_oe = 8'h00;
        ext_val = 8'h00;
        alt_pin3_in = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        // Reset state and read strobe timing
        chk("oe_rst", pin_oe_q, 8'h00);
        rd(PCP_OFF_DIR, PCP_DIR_RST);
        @(posedge clk);
        #1;
        chk("rdata_drop", bus_rdata_q, 8'h00);
        rd(PCP_OFF_LATCH, PCP_LATCH_RST);
        rd(2'h3, 8'h00);
        tend("reset");
        // Latch drives pins when direction is output
        wr(PCP_OFF_LATCH, 8'hA5);
        wr(PCP_OFF_DIR, 8'h00);
        setp('0, 8'h00, 8'h00, 1'b0);
        chk("oe_out", pin_oe_q, 8'hFF);
        chk("out_latch", pin_out_q, 8'hA5);
        wr(PCP_OFF_VALUE, 8'h5A);
        rd(PCP_OFF_LATCH, 8'h5A);
        // Inputs read pin levels, latch keeps its own contents
        wr(PCP_OFF_DIR, 8'hFF);
        setp('0, 8'hFF, 8'h3C, 1'b0);
        rd(PCP_OFF_VALUE, 8'h3C);
        rd(PCP_OFF_LATCH, 8'h5A);
        // Latch write then read with no idle cycle between the strobes
        @(posedge clk);
        bus_addr  <= PCP_OFF_LATCH;
        bus_wdata <= 8'h96;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr    <= 1'b0;
        bus_rd    <= 1'b1;
        @(posedge clk);
        bus_rd    <= 1'b0;
        #1;
        chk("lat_b2b", bus_rdata_q, 8'h96);
        tend("gpio");
        // Two-wire mode: drives beat latch ones, released lines are sampled
        r = '0;
        r.ssp_i2c = 1'b1;
        r.sda_drv = 1'b1;
        r.scl_drv = 1'b1;
        wr(PCP_OFF_LATCH, 8'hFF);
        setp(r, 8'h00, 8'h00, 1'b0);
        chk("i2c_oe", pin_oe_q & 8'h18, 8'h18);
        chk("i2c_out", pin_out_q & 8'h18, 8'h00);
        rd(PCP_OFF_DIR, 8'hFF);
        r.sda_drv = 1'b0;
        r.scl_drv = 1'b0;
        setp(r, 8'h18, 8'h10, 1'b0);
        chk("i2c_rel", pin_oe_q & 8'h18, 8'h00);
        chk("sda_in", {7'h00, per_in_q.sda_in}, 8'h01);
        chk("scl_in", {7'h00, per_in_q.scl_in}, 8'h00);
        tend("i2c");
        // SPI: data out on pin 5, data in on pin 4
        r = '0;
        r.ssp_spi = 1'b1;
        r.sdo = 1'b1;
        wr(PCP_OFF_LATCH, 8'h00);
        wr(PCP_OFF_DIR, 8'hDF);
        setp(r, 8'h10, 8'h10, 1'b0);
        chk("sdo", pin_out_q & pin_oe_q & 8'h20, 8'h20);
        chk("sdi", {7'h00, per_in_q.sdi}, 8'h01);
        tend("spi");
        // Asynchronous USART: transmit on 6, receive on 7 stays an input
        r = '0;
        r.ua_async = 1'b1;
        r.tx_out = 1'b1;
        wr(PCP_OFF_DIR, 8'h3F);
        setp(r, 8'h80, 8'h80, 1'b0);
        chk("tx", pin_out_q & pin_oe_q & 8'h40, 8'h40);
        chk("rx_oe", pin_oe_q & 8'h80, 8'h00);
        chk("rx", {7'h00, per_in_q.rx}, 8'h01);
        wr(PCP_OFF_DIR, 8'hFF);
        setp(r, 8'h80, 8'h80, 1'b0);
        chk("tx_dir", pin_oe_q & 8'h40, 8'h00);
        tend("async");
        // Synchronous master sending: clock and data forced out despite inputs
        r = '0;
        r.ua_sync = 1'b1;
        r.ua_master = 1'b1;
        r.uclk_out = 1'b1;
        r.udat_tx = 1'b1;
        r.udat_out = 1'b1;
        setp(r, 8'h00, 8'h00, 1'b0);
        chk("sync_oe", pin_oe_q & 8'hC0, 8'hC0);
        chk("sync_out", pin_out_q & 8'hC0, 8'hC0);
        // Synchronous slave receiving: both lines sampled
        r.ua_master = 1'b0;
        r.uclk_out = 1'b0;
        r.udat_tx = 1'b0;
        setp(r, 8'hC0, 8'hC0, 1'b0);
        chk("slave_oe", pin_oe_q & 8'hC0, 8'h00);
        chk("uclk_in", {7'h00, per_in_q.uclk_in}, 8'h01);
        chk("udat_in", {7'h00, per_in_q.udat_in}, 8'h01);
        tend("sync");
        // Second compare channel routing both ways
        r = '0;
        r.cmp2_route = 1'b1;
        r.cmp2_oe = 1'b1;
        r.cmp2_out = 1'b1;
        wr(PCP_OFF_DIR, 8'h00);
        setp(r, 8'h00, 8'h00, 1'b0);
        chk("cmp2_pin", pin_out_q & 8'h02, 8'h02);
        chk("cmp2_alt0", {7'h00, alt_cmp2_oe_q}, 8'h00);
        r.cmp2_route = 1'b0;
        setp(r, 8'h00, 8'h00, 1'b1);
        chk("cmp2_latch", pin_out_q & 8'h02, 8'h00);
        chk("cmp2_alt1", {6'h00, alt_cmp2_oe_q, alt_cmp2_out_q}, 8'h03);
        chk("cmp2_cap", {7'h00, per_in_q.cmp2_cap}, 8'h01);
        tend("cmp2");
        // Oscillator owns pins 0 and 1 whatever the direction; pin 2 compare drive
        r = '0;
        r.osc_en = 1'b1;
        r.cmp1_oe = 1'b1;
        r.cmp1_out = 1'b1;
        setp(r, 8'h03, 8'h03, 1'b0);
        chk("osc_oe", pin_oe_q & 8'h07, 8'h04);
        chk("cmp1_out", pin_out_q & 8'h04, 8'h04);
        chk("osc_in", {6'h00, per_in_q.tmr_in, per_in_q.cmp1_cap}, 8'h01);
        chk("sck_in", {7'h00, per_in_q.sck_in}, 8'h00);
        rd(PCP_OFF_VALUE, 8'h04);
        tend("osc");
        finish_test();
    end
endmodule : tb_pcp_port
